// [inc/ioj_map.svh]
/*
 * Constants for the five-instruction execution block: opcode patterns,
 * field positions, widths and reset values.
 * Assumes it is included by its bare name, after the package if needed.
 */
`ifndef IOJ_MAP_SVH
`define IOJ_MAP_SVH

// Instruction word width and field positions.
`define IOJ_INSTR_W 14
`define IOJ_DATA_W 8
`define IOJ_ADDR_W 7
`define IOJ_PC_W 13
`define IOJ_DEST_BIT 7
`define IOJ_PAGE_HI 4
`define IOJ_PAGE_LO 3

// Opcode patterns on the upper instruction bits.
`define IOJ_OP6_INC 6'h0A
`define IOJ_OP6_INCSZ 6'h0F
`define IOJ_OP6_OR_ACC_WITH_REGISTER 6'h04
`define IOJ_OP3_JUMP 3'h5
`define IOJ_OP6_OR_LITERAL_INTO_ACC 6'h38

// Reset values and file register depth.
`define IOJ_ACC_RST 8'h00
`define IOJ_PC_RST 13'h0000
`define IOJ_FILE_DEPTH 128

`endif

// [inc/ioj_pkg.sv]
/*
 * Types used by the execution block; its register file uses none of them.
 * Assumes nothing of its surroundings.
 */
package ioj_pkg;

   // Decoded operation classes.
   typedef enum logic [2:0] {
      IOJ_OP_NONE,
      IOJ_OP_INC,
      IOJ_OP_INCSZ,
      IOJ_OP_JUMP,
      IOJ_OP_ORLIT,
      IOJ_OP_ORREG
   } ioj_op_t;

   // Execution sequencer states.
   typedef enum logic [1:0] {
      IOJ_ST_EXEC,
      IOJ_ST_FLUSH
   } ioj_state_t;

endpackage : ioj_pkg

// [verilog/ioj_file_ram.sv]
/*
 * Small file-register memory of 128 bytes with one write port and one
 * registered read port.
 * Assumes a single clock; the read address is presented one cycle ahead.
 */
`timescale 1ns/1ps
`include "ioj_map.svh"

module ioj_file_ram (
   input wire logic ref_clk_i,
   input wire logic [`IOJ_ADDR_W-1:0] rd_addr_i,
   output logic [`IOJ_DATA_W-1:0] rd_data_o,
   input wire logic wr_en_i,
   input wire logic [`IOJ_ADDR_W-1:0] wr_addr_i,
   input wire logic [`IOJ_DATA_W-1:0] wr_data_i
);

   // Storage array; contents are undefined until first written.
   logic [`IOJ_DATA_W-1:0] mem_q [0:`IOJ_FILE_DEPTH-1];

   // Write port and registered read port.
   always_ff @(posedge ref_clk_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_q[rd_addr_i];
   end

endmodule : ioj_file_ram

// [verilog/ioj_exec.sv]
/*
 * Execution unit for increment, increment-with-skip, absolute jump and
 * the two inclusive-OR instructions of an 8-bit core.
 * Assumes the fetch side presents one instruction at a time with a valid
 * strobe, holds it until taken, and supplies the page latch value.
 */
// Summary of operation
// - Increment-skip result to accumulator or register.
// - Zero increment-skip result inserts an idle cycle.
// - Nonzero increment-skip result continues normally.
// - Jump loads eleven-bit immediate into PC low.
// - Jump copies page latch bits 4:3 up.
// - Jump is unconditional, two cycles, flags untouched.
// - OR literal into accumulator, update zero.
// - Increment register, route result, update zero.
// - OR accumulator with register, route, zero.
// - Zero flag set on zero result, else cleared; increment-skip leaves it unchanged.
`timescale 1ns/1ps
`include "ioj_map.svh"

module ioj_exec (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic instr_valid_i,
   input wire logic [`IOJ_INSTR_W-1:0] instr_i,
   input wire logic [`IOJ_DATA_W-1:0] program_counter_page_latch_i,
   output logic instr_ready_o,
   output logic [`IOJ_DATA_W-1:0] acc_o,
   output logic zero_flag_o,
   output logic [`IOJ_PC_W-1:0] pc_o,
   output logic idle_instruction_o,
   output logic done_o
);

   // Decode an instruction word into its operation class.
   function automatic ioj_pkg::ioj_op_t ioj_decode(
      input logic [`IOJ_INSTR_W-1:0] w);
      ioj_pkg::ioj_op_t op;
      op = ioj_pkg::IOJ_OP_NONE;
      if (w[13:11] == `IOJ_OP3_JUMP) begin
         op = ioj_pkg::IOJ_OP_JUMP;
      end else if (w[13:8] == `IOJ_OP6_INC) begin
         op = ioj_pkg::IOJ_OP_INC;
      end else if (w[13:8] == `IOJ_OP6_INCSZ) begin
         op = ioj_pkg::IOJ_OP_INCSZ;
      end else if (w[13:8] == `IOJ_OP6_OR_ACC_WITH_REGISTER) begin
         op = ioj_pkg::IOJ_OP_ORREG;
      end else if (w[13:8] == `IOJ_OP6_OR_LITERAL_INTO_ACC) begin
         op = ioj_pkg::IOJ_OP_ORLIT;
      end
      return op;
   endfunction : ioj_decode

   // True when an eight-bit result is all zeros; feeds the zero flag.
   function automatic logic ioj_is_zero(
      input logic [`IOJ_DATA_W-1:0] v);
      return (v == 8'h00);
   endfunction : ioj_is_zero

   // Program counter stepped forward by a number of words, wrapping.
   function automatic logic [`IOJ_PC_W-1:0] ioj_pc_step(
      input logic [`IOJ_PC_W-1:0] pc,
      input logic [`IOJ_PC_W-1:0] step);
      return pc + step;
   endfunction : ioj_pc_step

   // Sequencer phase: operand read, then result write-back.
   typedef enum logic [1:0] {
      IOJ_PH_IDLE,
      IOJ_PH_READ,
      IOJ_PH_EXEC
   } ioj_phase_t;

   ioj_phase_t phase_q, phase_d; // Sequencer phase: idle, operand read or execute.
   ioj_pkg::ioj_state_t state_q, state_d; // Normal or flushing cycle.
   logic [`IOJ_INSTR_W-1:0] ir_q, ir_d; // Instruction being executed.
   logic [`IOJ_DATA_W-1:0] acc_q, acc_d; // Accumulator.
   logic zero_q, zero_d; // Zero flag of the status register.
   logic [`IOJ_PC_W-1:0] pc_q, pc_d; // Program counter.
   logic idle_q, idle_d; // High for one cycle of idle execution.
   logic done_q, done_d; // One-cycle completion pulse.
   logic [`IOJ_DATA_W-1:0] file_rd; // Registered file read data.
   logic wr_en; // File write strobe.
   logic [`IOJ_DATA_W-1:0] result; // ALU result.
   logic [`IOJ_DATA_W-1:0] sum; // Wrapped increment result.
   ioj_pkg::ioj_op_t op; // Decoded class of the held instruction.

   // File register store, read one cycle after the address is given.
   // The operand address comes from the held word, so the fetch side may
   // change its word as soon as this one has been taken.
   ioj_file_ram u_ram (
      .ref_clk_i(ref_clk_i),
      .rd_addr_i(ir_q[`IOJ_ADDR_W-1:0]),
      .rd_data_o(file_rd),
      .wr_en_i(wr_en),
      .wr_addr_i(ir_q[`IOJ_ADDR_W-1:0]),
      .wr_data_i(result)
   );

   // Ready only while idle so the fetch side may present a new word.
   assign instr_ready_o = (phase_q == IOJ_PH_IDLE);
   assign op = ioj_decode(ir_q);
   assign sum = file_rd + 8'h01;

   // Result selection and the next-state logic for all execution state.
   always_comb begin
      phase_d = phase_q;
      state_d = state_q;
      ir_d = ir_q;
      acc_d = acc_q;
      zero_d = zero_q;
      pc_d = pc_q;
      idle_d = 1'b0;
      done_d = 1'b0;
      wr_en = 1'b0;
      result = 8'h00;
      unique case (phase_q)
         IOJ_PH_IDLE: begin
            // Take a new word and start the operand read.
            if (instr_valid_i) begin
               ir_d = instr_i;
               phase_d = IOJ_PH_READ;
            end
         end
         IOJ_PH_READ: begin
            // The held word addresses the store; data is ready next cycle.
            phase_d = IOJ_PH_EXEC;
         end
         IOJ_PH_EXEC: begin
            if (state_q == ioj_pkg::IOJ_ST_FLUSH) begin
               // Second cycle of a skip or jump runs as an idle slot.
               idle_d = 1'b1;
               done_d = 1'b1;
               state_d = ioj_pkg::IOJ_ST_EXEC;
               phase_d = IOJ_PH_IDLE;
            end else begin
               phase_d = IOJ_PH_IDLE;
               done_d = 1'b1;
               pc_d = ioj_pc_step(pc_q, 13'h0001);
               case (op)
                  ioj_pkg::IOJ_OP_INC,
                  ioj_pkg::IOJ_OP_INCSZ,
                  ioj_pkg::IOJ_OP_ORREG: begin
                     // Route to file register or accumulator.
                     result = (op == ioj_pkg::IOJ_OP_ORREG) ?
                        (acc_q | file_rd) : sum;
                     if (ir_q[`IOJ_DEST_BIT]) begin
                        // Target bit set: write back into the register.
                        wr_en = 1'b1;
                     end else begin
                        // Target bit clear: result goes to accumulator.
                        acc_d = result;
                     end
                     if (op != ioj_pkg::IOJ_OP_INCSZ) begin
                        zero_d = ioj_is_zero(result);
                     end else if (ioj_is_zero(result)) begin
                        // Skip the next word by an idle slot.
                        pc_d = ioj_pc_step(pc_q, 13'h0002);
                        state_d = ioj_pkg::IOJ_ST_FLUSH;
                        phase_d = IOJ_PH_EXEC;
                        done_d = 1'b0;
                     end
                  end
                  ioj_pkg::IOJ_OP_ORLIT: begin
                     // Literal OR always lands in the accumulator.
                     result = acc_q | ir_q[`IOJ_DATA_W-1:0];
                     acc_d = result;
                     zero_d = ioj_is_zero(result);
                  end
                  ioj_pkg::IOJ_OP_JUMP: begin
                     // Build the target; flags are not touched.
                     pc_d = {program_counter_page_latch_i[
                        `IOJ_PAGE_HI:`IOJ_PAGE_LO],
                        ir_q[10:0]};
                     state_d = ioj_pkg::IOJ_ST_FLUSH;
                     phase_d = IOJ_PH_EXEC;
                     done_d = 1'b0;
                  end
                  default: begin
                     // Other words are treated as one-cycle idle work.
                     idle_d = 1'b1;
                  end
               endcase
            end
         end
         default: begin
            phase_d = IOJ_PH_IDLE;
         end
      endcase
   end

   // Register every piece of execution state.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         phase_q <= IOJ_PH_IDLE;
         state_q <= ioj_pkg::IOJ_ST_EXEC;
         ir_q <= 14'h0000;
         acc_q <= `IOJ_ACC_RST;
         zero_q <= 1'b0;
         pc_q <= `IOJ_PC_RST;
         idle_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         state_q <= state_d;
         ir_q <= ir_d;
         acc_q <= acc_d;
         zero_q <= zero_d;
         pc_q <= pc_d;
         idle_q <= idle_d;
         done_q <= done_d;
      end
   end

   // Data outputs come straight from flip-flops.
   assign acc_o = acc_q;
   assign zero_flag_o = zero_q;
   assign pc_o = pc_q;
   assign idle_instruction_o = idle_q;
   assign done_o = done_q;

endmodule : ioj_exec

// [bench/ioj_exec_assertions.sv]
/* Port checker for the execution unit.
   Assumes it is bound to ioj_exec and that one clock drives it all. */
`timescale 1ns/1ps
`include "ioj_map.svh"
module ioj_exec_chk (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic instr_valid_i,
   input wire logic [13:0] instr_i,
   input wire logic [7:0] program_counter_page_latch_i,
   input wire logic instr_ready_o,
   input wire logic [7:0] acc_o,
   input wire logic zero_flag_o,
   input wire logic [12:0] pc_o,
   input wire logic idle_instruction_o,
   input wire logic done_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // A word is taken when it is offered while the unit is idle.
   wire tk = instr_valid_i && instr_ready_o;
   wire [5:0] op = instr_i[13:8];
   wire dst = instr_i[7];
   wire olit = op == `IOJ_OP6_OR_LITERAL_INTO_ACC;
   wire oreg = op == `IOJ_OP6_OR_ACC_WITH_REGISTER;
   wire isz = op == `IOJ_OP6_INCSZ;
   wire one = op == `IOJ_OP6_INC || oreg || olit;
   wire jmp = instr_i[13:11] == `IOJ_OP3_JUMP;
   AST_ONE_CYCLE: assert property (tk && one |=> !done_o [*2] ##1
      done_o && !idle_instruction_o) else $error("one-cycle op late");
   AST_JUMP_TIME: assert property (tk && jmp |=> !done_o [*3] ##1
      done_o && idle_instruction_o) else $error("jump not two cycles");
   AST_JUMP_PC: assert property (tk && jmp |-> ##3 pc_o ==
      {$past(program_counter_page_latch_i[4:3], 1), $past(instr_i[10:0], 3)})
      else $error("jump target wrong");
   AST_JUMP_FLAGS: assert property (tk && jmp |=>
      ($stable(acc_o) && $stable(zero_flag_o)) [*4]) else $error("jump flags");
   AST_OR_LIT: assert property (tk && olit |-> ##3 acc_o ==
      ($past(acc_o, 3) | $past(instr_i[7:0], 3))) else $error("or literal");
   AST_OR_REG: assert property (tk && oreg && !dst |-> ##3
      (acc_o & $past(acc_o, 3)) == $past(acc_o, 3)) else $error("or reg");
   AST_ACC_KEPT: assert property (tk && !olit && !jmp && dst |-> ##3
      acc_o == $past(acc_o, 3)) else $error("acc written for file dest");
   AST_ZERO: assert property (tk && one && !dst |-> ##3
      zero_flag_o == (acc_o == 8'h00)) else $error("zero flag");
   AST_SKIP_PC: assert property (tk && isz && !dst |-> ##3
      (acc_o == 8'h00) == (pc_o == $past(pc_o, 3) + 13'h0002))
      else $error("skip pc");
   AST_SKIP_TIME: assert property (
      tk && isz && !dst ##3 acc_o == 8'h00 |=> done_o && idle_instruction_o)
      else $error("skip slot missing");
   // Main scenarios: jump, skip taken, idle slot seen.
   cover property (tk && jmp);
   cover property (tk && isz && !dst ##3 acc_o == 8'h00);
   cover property (done_o && idle_instruction_o);
endmodule : ioj_exec_chk
bind ioj_exec ioj_exec_chk i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
   .instr_valid_i(instr_valid_i), .instr_i(instr_i),
   .program_counter_page_latch_i(program_counter_page_latch_i),
   .instr_ready_o(instr_ready_o), .acc_o(acc_o), .zero_flag_o(zero_flag_o),
   .pc_o(pc_o), .idle_instruction_o(idle_instruction_o), .done_o(done_o));

// [bench/inc_or_jump_exec_tb.sv]
/* Self-checking bench for the execution unit with a reference model.
   Assumes ioj_exec with the opcode map of ioj_map.svh. */
`timescale 1ns/1ps
`include "ioj_map.svh"
module inc_or_jump_exec_tb;
   logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, rdy, zf, idl, dn, zro = 1'b0;
   logic [13:0] ins = 14'h0000, w;
   logic [7:0] pgl = 8'h00, acc_o, acc = 8'h00, mem [128];
   logic [12:0] pc_o, pc = 13'h0000;
   logic [5:0] ops [4] = '{`IOJ_OP6_INC, `IOJ_OP6_INCSZ, `IOJ_OP6_OR_ACC_WITH_REGISTER,
      `IOJ_OP6_OR_LITERAL_INTO_ACC};
   logic [13:0] dir [6] = '{14'h0A05, 14'h3800, 14'h0F85, 14'h0F05, 14'h2FFF,
      14'h0000};
   int failures = 0, check_count = 0;
   ioj_exec i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .instr_valid_i(vld),
      .instr_i(ins), .program_counter_page_latch_i(pgl), .instr_ready_o(rdy),
      .acc_o(acc_o), .zero_flag_o(zf), .pc_o(pc_o),
      .idle_instruction_o(idl), .done_o(dn));
   // Clock of 50 ns period.
   initial forever #25 clk = ~clk;
   // Counts one comparison and reports a mismatch.
   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   // Offers one word, waits for completion and compares with the model.
   task automatic run(input logic [13:0] w);
      logic [7:0] r;
      logic jp, skip, un;
      int n;
      jp = w[13:11] == `IOJ_OP3_JUMP;
      un = !jp && w[13:8] != `IOJ_OP6_INC && w[13:8] != `IOJ_OP6_INCSZ &&
         w[13:8] != `IOJ_OP6_OR_ACC_WITH_REGISTER && w[13:8] != `IOJ_OP6_OR_LITERAL_INTO_ACC;
      skip = 1'b0;
      r = (w[13:8] == `IOJ_OP6_OR_LITERAL_INTO_ACC) ? acc | w[7:0] :
          (w[13:8] == `IOJ_OP6_OR_ACC_WITH_REGISTER) ? acc | mem[w[6:0]] :
          mem[w[6:0]] + 8'h01;
      n = 0;
      while (rdy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      vld <= 1'b1;
      ins <= w;
      pgl <= 8'($urandom);
      @(posedge clk);
      vld <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (dn !== 1'b1 && n < 8);
      if (jp) pc = {pgl[4:3], w[10:0]};
      else if (un) pc = pc + 13'h0001;
      else begin
         skip = w[13:8] == `IOJ_OP6_INCSZ && r == 8'h00;
         pc = pc + (skip ? 13'h0002 : 13'h0001);
         if (w[13:12] != 2'h3 && w[7]) mem[w[6:0]] = r;
         else acc = r;
         if (w[13:8] != `IOJ_OP6_INCSZ) zro = r == 8'h00;
      end
      chk(13'(n), (jp || skip) ? 13'h0004 : 13'h0003);
      chk(13'(idl), 13'(jp || skip || un));
      chk(13'(acc_o), 13'(acc));
      chk(13'(zf), 13'(zro));
      chk(pc_o, pc);
   endtask : run
   // Prints the counts and the verdict, then stops.
   task automatic results;
      $display("Checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   // Watchdog well beyond the expected run length.
   initial begin
      #1000000;
      failures++;
      results();
   end
   // Reset, seed every file register to FF, corners, then random words.
   initial begin
      void'($urandom(32'hC354));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk({acc_o, zf, rdy}, 13'h0001);
      chk(pc_o, 13'h0000);
      run(14'h38FF);
      for (int a = 0; a < 128; a++) run({6'h04, 1'b1, 7'(a)});
      foreach (dir[i]) run(dir[i]);
      for (int i = 0; i < 400; i++) begin
         w = 14'($urandom);
         if (i % 5 == 4) w[13:11] = `IOJ_OP3_JUMP;
         else w[13:8] = ops[$urandom % 4];
         run(w);
      end
      results();
   end
endmodule : inc_or_jump_exec_tb
